// ==== core/sat_mul.sv ====
// unsigned multiply, shift down and saturate
`default_nettype none
module sat_mul #(
  parameter int AW = 20,
  parameter int BW = 8,
  parameter int SH = 8,
  parameter int OW = 20
) (
  input wire logic [AW-1:0] a,
  input wire logic [BW-1:0] b,
  output logic [OW-1:0] y
);
  logic [AW+BW-1:0] prod; // full product
  logic [AW+BW-1:0] shifted; // after fixed-point scale
  assign prod = a * b;
  assign shifted = prod >> SH;
  // clip rather than wrap, a wrapped pixel is a visible artefact
  assign y = (|shifted[AW+BW-1:OW]) ? {OW{1'b1}} : shifted[OW-1:0];
endmodule
`default_nettype wire

// ==== core/wdr_tm_core.sv ====
// wdr compression, shading gain and local tone mapping with apb registers
`include "wdr_tm_params.svh"
`default_nettype none
module wdr_tm_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] exposure_meas,
  input wire wdr_tm_pkg::pix_in_t pix_in,
  output var wdr_tm_pkg::pix_out_t pix_out
);
  import wdr_tm_pkg::*;

  // writable bits of a register; zero marks an unmapped index
  function automatic logic [7:0] reg_mask(input logic [7:0] i);
    logic [7:0] m;
    m = 8'h00;
    if (i >= `KNEE_IN1_TOP && i <= `KNEE_OUT5_BOTTOM) begin
      m = 8'hFF;
    end
    if (i >= `DARK_SLOPE_IDX && i <= `SGAIN_MON_IDX) begin
      m = 8'hFF;
    end
    if (i >= `SHADE_STRENGTH_IDX && i <= `SHADE_ROW_IDX) begin
      m = 8'hFF;
    end
    if (i >= `SGAIN_BASE_IDX && i < `SGAIN_BASE_IDX + 8'h06) begin
      m = 8'hFF;
    end
    if (i >= `SMIN_BASE_IDX && i < `WEIGHT_IDX) begin
      m = 8'hFF;
    end
    case (i)
      `KNEE_IN1_TOP, `KNEE_IN2_TOP, `KNEE_IN3_TOP, `KNEE_IN4_TOP: m = `KNEE_IN_TOP_MASK;
      `KNEE_OUT0_TOP, `KNEE_OUT1_TOP, `KNEE_OUT2_TOP: m = `KNEE_OUT_TOP_MASK;
      `KNEE_OUT3_TOP, `KNEE_OUT4_TOP, `KNEE_OUT5_TOP: m = `KNEE_OUT_TOP_MASK;
      `CTRL_IDX: m = `CTRL_MASK;
      `WEIGHT_IDX: m = `WEIGHT_MASK;
      default: m = m;
    endcase
    return m;
  endfunction

  // reset value of each register
  function automatic logic [7:0] reg_rst(input logic [7:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i >= `SGAIN_BASE_IDX && i < `SGAIN_BASE_IDX + 8'h06) begin
      v = `SGAIN_RST;
    end
    if (i >= `CGAIN_BASE_IDX && i < `WEIGHT_IDX) begin
      v = `CGAIN_RST;
    end
    case (i)
      `KNEE_IN1_MIDDLE: v = `KNEE_IN1_MIDDLE_RST;
      `KNEE_IN2_MIDDLE: v = `KNEE_IN2_MIDDLE_RST;
      `KNEE_IN3_TOP: v = `KNEE_IN3_TOP_RST;
      `KNEE_IN4_TOP: v = `KNEE_IN4_TOP_RST;
      `KNEE_OUT1_TOP: v = `KNEE_OUT1_TOP_RST;
      `KNEE_OUT2_TOP: v = `KNEE_OUT2_TOP_RST;
      `KNEE_OUT3_TOP: v = `KNEE_OUT3_TOP_RST;
      `KNEE_OUT3_BOTTOM: v = `KNEE_OUT3_BOTTOM_RST;
      `KNEE_OUT4_TOP: v = `KNEE_OUT4_TOP_RST;
      `KNEE_OUT5_TOP: v = `KNEE_OUT5_TOP_RST;
      `KNEE_OUT5_BOTTOM: v = `KNEE_OUT5_BOTTOM_RST;
      `DARK_SLOPE_IDX, `BRIGHT_F1_IDX, `BRIGHT_F2_IDX: v = `SLOPE_RST;
      `SHADE_STRENGTH_IDX: v = `SHADE_STRENGTH_RST;
      `WEIGHT_IDX: v = `WEIGHT_RST;
      default: v = v;
    endcase
    return v;
  endfunction

  logic [7:0] regs_r [0:255]; // software settings, sparse
  logic [7:0] mon_r; // applied sigma gain
  logic [31:0] prdata_r; // read data captured in setup
  cfg_t act_r; // working set of the current frame
  cfg_t cfg_nxt; // set to adopt at next frame start
  pix_in_t s1_r; // registered input pixel
  pix_out_t out_r; // registered result

  // ---- apb decode ----
  logic [7:0] idx; // register index
  logic hit; // aligned and mapped
  logic setup_rd; // read setup phase
  logic wr_en; // write commits
  logic [7:0] rd_byte; // selected read value
  assign idx = paddr[9:2];
  assign hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && (reg_mask(idx) != 8'h00);
  assign setup_rd = psel && !penable && !pwrite;
  // monitor is read-only, writes to it are dropped without error
  assign wr_en = psel && penable && pwrite && hit && (idx != `SGAIN_MON_IDX);
  assign rd_byte = (idx == `SGAIN_MON_IDX) ? mon_r : (regs_r[idx] & reg_mask(idx));
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;

  // register array; writes commit at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        regs_r[i] <= reg_rst(8'(i));
      end
    end else if (wr_en) begin
      regs_r[idx] <= pwdata[7:0] & reg_mask(idx);
    end
  end

  // read data registered in setup so the bus sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_r <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ---- exposure level, nearest of six evenly spaced ----
  logic [2:0] lvl;
  assign lvl = {2'b00, exposure_meas >= `EXP_MID1} + {2'b00, exposure_meas >= `EXP_MID2}
             + {2'b00, exposure_meas >= `EXP_MID3} + {2'b00, exposure_meas >= `EXP_MID4}
             + {2'b00, exposure_meas >= `EXP_MID5};

  // assemble the pending set from the registers
  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.shade_en = regs_r[`CTRL_IDX][`CTRL_SHADE_BIT];
    cfg_nxt.tonemap_enable = regs_r[`CTRL_IDX][`CTRL_TM_BIT];
    cfg_nxt.strength = regs_r[`SHADE_STRENGTH_IDX];
    cfg_nxt.centre_col = regs_r[`SHADE_COL_IDX];
    cfg_nxt.centre_row = regs_r[`SHADE_ROW_IDX];
    for (int k = 0; k < 4; k++) begin
      cfg_nxt.knee_in[k] = {regs_r[8'(`KNEE_IN1_TOP + 3 * k)][1:0],
                            regs_r[8'(`KNEE_IN1_MIDDLE + 3 * k)],
                            regs_r[8'(`KNEE_IN1_BOTTOM + 3 * k)]};
    end
    for (int k = 0; k < 6; k++) begin
      cfg_nxt.knee_out[k] = {regs_r[8'(`KNEE_OUT0_TOP + 2 * k)][3:0],
                             regs_r[8'(`KNEE_OUT0_BOTTOM + 2 * k)]};
    end
    cfg_nxt.dark_slope = regs_r[`DARK_SLOPE_IDX];
    cfg_nxt.bright_f1 = regs_r[`BRIGHT_F1_IDX];
    cfg_nxt.bright_f2 = regs_r[`BRIGHT_F2_IDX];
    cfg_nxt.weight = regs_r[`WEIGHT_IDX][4:0];
    // per-level sets picked by exposure
    cfg_nxt.sigma_gain = regs_r[`SGAIN_BASE_IDX + {5'b0, lvl}];
    cfg_nxt.sigma_min = regs_r[`SMIN_BASE_IDX + {5'b0, lvl}];
    cfg_nxt.colour_gain = regs_r[`CGAIN_BASE_IDX + {5'b0, lvl}];
    cfg_nxt.detail_gain = regs_r[`DGAIN_BASE_IDX + {5'b0, lvl}];
  end

  // adopt a new set only on the first pixel of a frame
  logic frame_start;
  assign frame_start = pix_in.vld && pix_in.sof;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= '0;
      mon_r <= 8'h00;
    end else if (frame_start) begin
      act_r <= cfg_nxt;
      mon_r <= cfg_nxt.sigma_gain;
    end
  end

  // input register; stage two then sees the new set on sof
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
    end else begin
      s1_r <= pix_in;
    end
  end

  // ---- radial shading gain ----
  logic [11:0] cx, cy, dx, dy; // centre and distance
  logic [23:0] dx2, dy2;
  logic [24:0] r2; // squared radius
  logic [11:0] shade_extra; // gain above unity
  logic [12:0] shade_gain; // 8 fraction bits
  logic [19:0] pix_sh, luma_sh; // corrected sample and luma
  assign cx = {1'b0, act_r.centre_col, 3'b000};
  assign cy = {1'b0, act_r.centre_row, 3'b000};
  assign dx = (s1_r.col >= cx) ? s1_r.col - cx : cx - s1_r.col;
  assign dy = (s1_r.row >= cy) ? s1_r.row - cy : cy - s1_r.row;
  assign dx2 = dx * dx;
  assign dy2 = dy * dy;
  assign r2 = {1'b0, dx2} + {1'b0, dy2};
  sat_mul #(.AW(25), .BW(8), .SH(`SHADE_R2_SHIFT), .OW(12)) u_shade (
    .a(r2), .b(act_r.strength), .y(shade_extra));
  assign shade_gain = act_r.shade_en ? `SHADE_UNITY + {1'b0, shade_extra} : `SHADE_UNITY;
  sat_mul #(.AW(20), .BW(13), .SH(`PIX_SHIFT), .OW(20)) u_pix (
    .a(s1_r.data), .b(shade_gain), .y(pix_sh));
  sat_mul #(.AW(20), .BW(13), .SH(`PIX_SHIFT), .OW(20)) u_luma (
    .a(s1_r.luma), .b(shade_gain), .y(luma_sh));

  // ---- piece-wise linear compression ----
  logic [11:0] knee_val;
  always_comb begin
    logic [17:0] x, x0, x1;
    logic [11:0] y0, y1, dyk;
    logic [29:0] num;
    logic [29:0] step;
    logic [2:0] seg;
    x = (|pix_sh[19:18]) ? `KNEE_X_MAX : pix_sh[17:0];
    seg = 3'd0;
    for (int k = 0; k < 4; k++) begin
      if (x >= act_r.knee_in[k]) begin
        seg = 3'(k + 1);
      end
    end
    x0 = (seg == 3'd0) ? 18'h0_0000 : act_r.knee_in[seg - 3'd1];
    x1 = (seg == 3'd4) ? `KNEE_X_MAX : act_r.knee_in[seg[1:0]];
    y0 = act_r.knee_out[seg];
    y1 = act_r.knee_out[seg + 3'd1];
    dyk = (y1 > y0) ? y1 - y0 : 12'h000;
    num = (x - x0) * dyk;
    step = (x1 > x0) ? num / {12'h000, x1 - x0} : 30'h0;
    // past the last knee point the curve climbs toward five, reached only at full scale
    knee_val = (x >= x1) ? y1 : y0 + step[11:0];
  end

  // ---- sigma contrast, gain, floor and weighting ----
  logic [19:0] s_loc, g_glb, dark_diff, bright_diff, dark_adj, bright_adj;
  logic [15:0] bright_slope;
  logic [20:0] bright_sum;
  logic [19:0] s_con, s_gain, s_floor, s_min, sw;
  logic [4:0] w;
  logic [24:0] blend;
  logic is_dark;
  assign s_loc = s1_r.local_sigma;
  assign g_glb = s1_r.global_sigma;
  assign is_dark = s_loc < g_glb;
  assign dark_diff = is_dark ? g_glb - s_loc : 20'h0_0000;
  assign bright_diff = is_dark ? 20'h0_0000 : s_loc - g_glb;
  sat_mul #(.AW(20), .BW(8), .SH(`DARK_SHIFT), .OW(20)) u_dark (
    .a(dark_diff), .b(act_r.dark_slope), .y(dark_adj));
  assign bright_slope = act_r.bright_f1 * act_r.bright_f2;
  sat_mul #(.AW(20), .BW(16), .SH(`BRIGHT_SHIFT), .OW(20)) u_bright (
    .a(bright_diff), .b(bright_slope), .y(bright_adj));
  assign bright_sum = {1'b0, g_glb} + {1'b0, bright_adj};
  // steeper dark slope pulls sigma down, steeper bright slope up
  assign s_con = is_dark ? ((g_glb > dark_adj) ? g_glb - dark_adj : 20'h0_0000)
               : (bright_sum[20] ? 20'hF_FFFF : bright_sum[19:0]);
  sat_mul #(.AW(20), .BW(8), .SH(`SGAIN_SHIFT), .OW(20)) u_sgain (
    .a(s_con), .b(act_r.sigma_gain), .y(s_gain));
  assign s_floor = {act_r.sigma_min, 12'h000};
  assign s_min = (s_gain < s_floor) ? s_floor : s_gain;
  assign w = (act_r.weight > `WEIGHT_FULL) ? `WEIGHT_FULL : act_r.weight;
  assign blend = w * s_min + (`WEIGHT_FULL - w) * g_glb;
  assign sw = blend[23:4];

  // ---- tone curve and bayer rebuild ----
  logic [31:0] tm_num;
  logic [20:0] tm_den;
  logic [31:0] tm_quo;
  logic [11:0] tm_luma;
  logic signed [20:0] c_diff, d_diff;
  logic signed [29:0] c_prod, d_prod, c_adj, d_adj;
  logic signed [31:0] merged;
  logic [11:0] tone_val;
  // luma over luma plus sigma: bigger sigma, darker result
  assign tm_num = luma_sh * `TONE_MAX;
  assign tm_den = {1'b0, luma_sh} + {1'b0, sw} + 21'h00_0001;
  assign tm_quo = tm_num / {11'h000, tm_den};
  assign tm_luma = tm_quo[11:0];
  // colour is the sample's offset from luma, detail luma's from sigma
  assign c_diff = $signed({1'b0, pix_sh}) - $signed({1'b0, luma_sh});
  assign d_diff = $signed({1'b0, luma_sh}) - $signed({1'b0, s_loc});
  assign c_prod = c_diff * $signed({1'b0, act_r.colour_gain});
  assign d_prod = d_diff * $signed({1'b0, act_r.detail_gain});
  assign c_adj = c_prod >>> `TONE_GAIN_SHIFT;
  assign d_adj = d_prod >>> `TONE_GAIN_SHIFT;
  assign merged = $signed({20'h0_0000, tm_luma}) + 32'(c_adj) + 32'(d_adj);
  assign tone_val = (merged < 0) ? 12'h000
                  : ((merged > $signed({20'h0_0000, `TONE_MAX})) ? `TONE_MAX : merged[11:0]);

  // output register; bypass keeps the low bits of the sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
    end else begin
      out_r.vld <= s1_r.vld;
      out_r.sof <= s1_r.sof;
      out_r.tone <= act_r.tonemap_enable ? tone_val : pix_sh[11:0];
      out_r.knee <= knee_val;
    end
  end
  assign pix_out = out_r;

  // ---- checks ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BYPASS: assert property (s1_r.vld && !act_r.tonemap_enable
      |=> pix_out.tone == $past(pix_sh[11:0]))
    else $error("bypass did not pass low bits");
  AST_SHADE_OFF: assert property (s1_r.vld && !act_r.shade_en |-> pix_sh == s1_r.data)
    else $error("shading applied while disabled");
  AST_KNEE_TOP: assert property (s1_r.vld && (|pix_sh[19:18])
      |=> pix_out.knee == $past(act_r.knee_out[5]))
    else $error("saturated input missed top point");
  AST_MONITOR: assert property (frame_start |=> mon_r == act_r.sigma_gain
      && mon_r == $past(regs_r[`SGAIN_BASE_IDX + {5'b0, lvl}]))
    else $error("monitor differs from applied gain");
  AST_FRAME_HOLD: assert property (!frame_start |=> $stable(act_r) && $stable(mon_r))
    else $error("settings changed inside a frame");
  AST_FLOOR: assert property (s1_r.vld && act_r.weight >= `WEIGHT_FULL |-> sw >= s_floor)
    else $error("weighted sigma under minimum");
  AST_GLOBAL: assert property (s1_r.vld && act_r.weight == 5'h00 |-> sw == g_glb)
    else $error("zero weight not purely global");
  AST_LEVEL: assert property (exposure_meas < `EXP_MID1 |-> ##0 lvl == 3'd0)
    else $error("low exposure not on level zero");
  AST_DARK_WRITE: assert property (wr_en && idx == `DARK_SLOPE_IDX
      |=> regs_r[`DARK_SLOPE_IDX] == $past(pwdata[7:0]))
    else $error("dark slope write lost");
  AST_LATENCY: assert property (pix_in.vld |-> ##2 pix_out.vld)
    else $error("pixel lost in pipeline");
endmodule
`default_nettype wire

// ==== core/wdr_tm_params.svh ====
// register indices, reset values and fixed-point scales of the wdr stage
`ifndef WDR_TM_PARAMS_SVH
`define WDR_TM_PARAMS_SVH
// register indices; byte address is four times the index
`define KNEE_IN1_TOP 8'hB5
`define KNEE_IN1_MIDDLE 8'hB6
`define KNEE_IN1_BOTTOM 8'hB7
`define KNEE_IN2_TOP 8'hB8
`define KNEE_IN2_MIDDLE 8'hB9
`define KNEE_IN2_BOTTOM 8'hBA
`define KNEE_IN3_TOP 8'hBB
`define KNEE_IN3_MIDDLE 8'hBC
`define KNEE_IN3_BOTTOM 8'hBD
`define KNEE_IN4_TOP 8'hBE
`define KNEE_IN4_MIDDLE 8'hBF
`define KNEE_IN4_BOTTOM 8'hC0
`define KNEE_OUT0_TOP 8'hC1
`define KNEE_OUT0_BOTTOM 8'hC2
`define KNEE_OUT1_TOP 8'hC3
`define KNEE_OUT1_BOTTOM 8'hC4
`define KNEE_OUT2_TOP 8'hC5
`define KNEE_OUT2_BOTTOM 8'hC6
`define KNEE_OUT3_TOP 8'hC7
`define KNEE_OUT3_BOTTOM 8'hC8
`define KNEE_OUT4_TOP 8'hC9
`define KNEE_OUT4_BOTTOM 8'hCA
`define KNEE_OUT5_TOP 8'hCB
`define KNEE_OUT5_BOTTOM 8'hCC
`define CTRL_IDX 8'h04
`define DARK_SLOPE_IDX 8'h58
`define BRIGHT_F1_IDX 8'h59
`define BRIGHT_F2_IDX 8'h5A
`define SGAIN_MON_IDX 8'h5B
`define SHADE_STRENGTH_IDX 8'h80
`define SHADE_COL_IDX 8'h81
`define SHADE_ROW_IDX 8'h82
`define SGAIN_BASE_IDX 8'hA8
`define SMIN_BASE_IDX 8'hD0
`define CGAIN_BASE_IDX 8'hD6
`define DGAIN_BASE_IDX 8'hDC
`define WEIGHT_IDX 8'hE2
// control bit positions and masks
`define CTRL_SHADE_BIT 6
`define CTRL_TM_BIT 4
`define CTRL_MASK 8'h50
`define KNEE_IN_TOP_MASK 8'h03
`define KNEE_OUT_TOP_MASK 8'h0F
`define WEIGHT_MASK 8'h1F
// reset values
`define KNEE_IN1_MIDDLE_RST 8'h40
`define KNEE_IN2_MIDDLE_RST 8'h80
`define KNEE_IN3_TOP_RST 8'h01
`define KNEE_IN4_TOP_RST 8'h02
`define KNEE_OUT1_TOP_RST 8'h04
`define KNEE_OUT2_TOP_RST 8'h06
`define KNEE_OUT3_TOP_RST 8'h08
`define KNEE_OUT3_BOTTOM_RST 8'h80
`define KNEE_OUT4_TOP_RST 8'h0C
`define KNEE_OUT5_TOP_RST 8'h0F
`define KNEE_OUT5_BOTTOM_RST 8'hFF
`define SLOPE_RST 8'h08
`define SHADE_STRENGTH_RST 8'h80
`define SGAIN_RST 8'h10
`define CGAIN_RST 8'h40
`define WEIGHT_RST 8'h10
// fixed-point scales
`define DARK_SHIFT 3
`define BRIGHT_SHIFT 6
`define SGAIN_SHIFT 4
`define TONE_GAIN_SHIFT 14
`define WEIGHT_FULL 5'h10
`define SHADE_UNITY 13'h0100
`define SHADE_R2_SHIFT 20
`define PIX_SHIFT 8
`define KNEE_X_MAX 18'h3FFFF
`define TONE_MAX 12'hFFF
// exposure midpoints between the six levels
`define EXP_MID1 8'h1A
`define EXP_MID2 8'h4D
`define EXP_MID3 8'h80
`define EXP_MID4 8'hB3
`define EXP_MID5 8'hE6
`endif

// ==== core/wdr_tm_pkg.sv ====
// pixel and configuration types of the wdr stage
`default_nettype none
package wdr_tm_pkg;
  // merged wdr pixel from upstream with its luma and sigmas
  typedef struct packed {
    logic vld;
    logic sof;
    logic [11:0] col;
    logic [11:0] row;
    logic [19:0] data;
    logic [19:0] luma;
    logic [19:0] local_sigma;
    logic [19:0] global_sigma;
  } pix_in_t;
  // result towards the output formatter
  typedef struct packed {
    logic vld;
    logic sof;
    logic [11:0] tone;
    logic [11:0] knee;
  } pix_out_t;
  // frame-stable working set
  typedef struct packed {
    logic shade_en;
    logic tonemap_enable;
    logic [7:0] strength;
    logic [7:0] centre_col;
    logic [7:0] centre_row;
    logic [3:0][17:0] knee_in;
    logic [5:0][11:0] knee_out;
    logic [7:0] dark_slope;
    logic [7:0] bright_f1;
    logic [7:0] bright_f2;
    logic [4:0] weight;
    logic [7:0] sigma_gain;
    logic [7:0] sigma_min;
    logic [7:0] colour_gain;
    logic [7:0] detail_gain;
  } cfg_t;
endpackage
`default_nettype wire

// ==== sim/pix_stream_model.sv ====
// pixel stream partner: upstream merge source and downstream formatter sink
`default_nettype none
module pix_stream_model (
  input wire logic pclk,
  output var wdr_tm_pkg::pix_in_t pix_in,
  input wire wdr_tm_pkg::pix_out_t pix_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import wdr_tm_pkg::*;
  logic [11:0] tone; // last tone sample taken by the sink
  logic [11:0] knee; // last knee sample taken by the sink
  logic sof_o; // last frame-start mark taken by the sink
  logic got; // output strobe seen two cycles after the input strobe
  initial pix_in = '0;
  // one merged pixel, then the sink looks at the result cycle
  task automatic send(input logic sof, input logic [11:0] col, input logic [19:0] data,
    input logic [19:0] luma, input logic [19:0] ls, input logic [19:0] gs);
    @(posedge pclk);
    pix_in <= '{1'b1, sof, col, 12'h000, data, luma, ls, gs};
    @(posedge pclk);
    // released fields show the inverse so a stale value is never mistaken for data
    pix_in <= {1'b0, ~pix_in[$bits(pix_in_t)-2:0]};
    @(posedge pclk);
    #1;
    got = pix_out.vld;
    tone = pix_out.tone;
    knee = pix_out.knee;
    sof_o = pix_out.sof;
  endtask
endmodule
`default_nettype wire

// ==== sim/wdr_compress_shading_tonemap_tb.sv ====
// self-checking bench of the wdr compression, shading and tone stage
`default_nettype none
module wdr_compress_shading_tonemap_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdr_tm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0; // active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] exposure_meas = 8'h00;
  pix_in_t pix_in;
  pix_out_t pix_out;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rdv; // last read data
  logic erv; // last error response
  logic [11:0] t0;
  logic [11:0] t1;
  // index in the upper byte, reset value in the lower
  logic [15:0] rst_tab [18] = '{16'hB500, 16'hB640, 16'hBB01, 16'hBE02, 16'hC304, 16'hC880,
    16'hC90C, 16'hCB0F, 16'hCCFF, 16'h0400, 16'h5808, 16'h5908, 16'h5A08, 16'h5B00,
    16'h8080, 16'h8100, 16'hA810, 16'hAD10};
  // curve input in the upper bits, expected knee output in the low twelve
  logic [31:0] knee_tab [8] = '{32'h02000200, 32'h04000400, 32'h08000600, 32'h10000880,
    32'h18000A40, 32'h20000C00, 32'h3FFFFFFF, 32'hFFFFFFFF};
  // exposure in the upper byte, nearest level in the low nibble
  logic [11:0] exp_tab [10] = '{12'h000, 12'h190, 12'h1A1, 12'h331, 12'h662, 12'h803,
    12'h993, 12'hCC4, 12'hE65, 12'hFF5};
  wdr_tm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exposure_meas(exposure_meas), .pix_in(pix_in), .pix_out(pix_out));
  pix_stream_model model_u (.pclk(pclk), .pix_in(pix_in), .pix_out(pix_out));
  // 100 MHz clock
  initial begin
    forever #5 pclk = ~pclk;
  end
  // hang guard, well above the length of the sequence
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; waits for pready at a rising edge, the guard ends a hang
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, {2'b00, idx, 2'b00}, v);
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
  endtask
  // pixel with a fixed global sigma; the result strobe must land on time
  task automatic px(input logic sof, input logic [11:0] col, input logic [19:0] data,
    input logic [19:0] luma, input logic [19:0] ls);
    model_u.send(sof, col, data, luma, ls, 20'h40000);
    chk("output strobe", 32'h1, {31'h0, model_u.got});
    chk("output sof", {31'h0, sof}, {31'h0, model_u.sof_o});
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][15:8]);
      chk("reset value", {24'h0, rst_tab[i][7:0]}, rdv);
    end
    apb(1'b0, 12'h040, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, erv});
    chk("unmapped data", 32'h0, rdv);
    apb(1'b1, 12'h2D5, 8'h11);
    chk("misaligned error", 32'h1, {31'h0, erv});
    wr(8'hB5, 8'hFF);
    rd(8'hB5);
    chk("knee top width", 32'h03, rdv);
    wr(8'hB5, 8'h00);
    wr(8'h5B, 8'h77);
    rd(8'h5B);
    chk("monitor read only", 32'h00, rdv);
    // curve at reset knees, tone path bypassed
    foreach (knee_tab[i]) begin
      px(i == 0, 12'h000, knee_tab[i][31:12], 20'h00000, 20'h00000);
      chk("knee output", {20'h0, knee_tab[i][11:0]}, {20'h0, model_u.knee});
      chk("bypass tone", {20'h0, knee_tab[i][23:12]}, {20'h0, model_u.tone});
    end
    // per-level sigma gains, nearest level picked at frame start
    for (int k = 0; k < 6; k++) begin
      wr(8'hA8 + 8'(k), 8'h20 + 8'(k));
    end
    foreach (exp_tab[i]) begin
      @(posedge pclk);
      exposure_meas <= exp_tab[i][11:4];
      px(1'b1, 12'h000, 20'h00100, 20'h00100, 20'h00100);
      rd(8'h5B);
      chk("level gain", {28'h2, exp_tab[i][3:0]}, rdv);
    end
    @(posedge pclk);
    exposure_meas <= 8'h00;
    px(1'b1, 12'h000, 20'h00100, 20'h00100, 20'h00100);
    wr(8'hA8, 8'h10);
    px(1'b0, 12'h000, 20'h00100, 20'h00100, 20'h00100);
    rd(8'h5B);
    chk("gain held in frame", 32'h20, rdv);
    px(1'b1, 12'h000, 20'h00100, 20'h00100, 20'h00100);
    rd(8'h5B);
    chk("gain at frame start", 32'h10, rdv);
    // shading with tone bypass, centre at pixel zero
    wr(8'h04, 8'h40);
    px(1'b1, 12'h000, 20'h00100, 20'h00100, 20'h0);
    chk("shade at centre", 32'h100, {20'h0, model_u.tone});
    // column 0x100 is far enough out for a nonzero gain step at half strength
    px(1'b1, 12'h100, 20'h00100, 20'h00100, 20'h0);
    t0 = model_u.tone;
    chk("shade off centre", 32'h1, {31'h0, t0 > 12'h100});
    wr(8'h80, 8'hFF);
    px(1'b1, 12'h100, 20'h00100, 20'h00100, 20'h0);
    chk("shade strength up", 32'h1, {31'h0, model_u.tone > t0});
    wr(8'h80, 8'h00);
    px(1'b1, 12'h100, 20'h00100, 20'h00100, 20'h0);
    chk("shade strength zero", 32'h100, {20'h0, model_u.tone});
    wr(8'h80, 8'h80);
    wr(8'h81, 8'h20);
    px(1'b1, 12'h100, 20'h00100, 20'h00100, 20'h0);
    chk("shade moved centre", 32'h100, {20'h0, model_u.tone});
    wr(8'h04, 8'h00);
    wr(8'h81, 8'h00);
    px(1'b1, 12'h100, 20'h00100, 20'h00100, 20'h0);
    chk("shade disabled", 32'h100, {20'h0, model_u.tone});
    // tone mapping, dark pixel below and bright pixel above the global sigma
    wr(8'h04, 8'h10);
    // no detail term yet, so the dark pixel stays clear of the 12-bit clip
    wr(8'hDC, 8'h00);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h08000);
    t0 = model_u.tone;
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h80000);
    t1 = model_u.tone;
    chk("tone vs local sigma", 32'h1, {31'h0, t0 > t1});
    wr(8'hA8, 8'h40);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h08000);
    chk("tone vs sigma gain", 32'h1, {31'h0, model_u.tone < t0});
    wr(8'hA8, 8'h10);
    wr(8'h58, 8'h20);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h08000);
    chk("tone vs dark slope", 32'h1, {31'h0, model_u.tone > t0});
    wr(8'h58, 8'h08);
    wr(8'h59, 8'h10);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h80000);
    chk("tone vs bright slope", 32'h1, {31'h0, model_u.tone < t1});
    wr(8'h59, 8'h08);
    wr(8'hDC, 8'h00);
    wr(8'hE2, 8'h00);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h08000);
    t0 = model_u.tone;
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h80000);
    chk("global only tone", {20'h0, t0}, {20'h0, model_u.tone});
    wr(8'hDC, 8'h40);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h08000);
    chk("detail gain", 32'h1, {31'h0, model_u.tone > t0});
    wr(8'hD6, 8'h00);
    px(1'b1, 12'h000, 20'h50000, 20'h40000, 20'h08000);
    t0 = model_u.tone;
    wr(8'hD6, 8'h80);
    px(1'b1, 12'h000, 20'h50000, 20'h40000, 20'h08000);
    chk("colour gain", 32'h1, {31'h0, model_u.tone > t0});
    wr(8'hE2, 8'h10);
    wr(8'hDC, 8'h00);
    wr(8'hD0, 8'hFF);
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h00000);
    t0 = model_u.tone;
    px(1'b1, 12'h000, 20'h40000, 20'h40000, 20'h01000);
    chk("sigma floor", {20'h0, t0}, {20'h0, model_u.tone});
    report_and_stop();
  end
endmodule
`default_nettype wire
